// ===== acd_command_decoder.sv
// Serial command decoder and result framer for the multi-channel converter
//
// Summary of operation
// - Bit7 zero, bit6 one selects setup
// - Clock-mode field picks clock and start source
// - Reference field picks reference and power
// - Pair select 0x: no byte follows
// - Pair select 1x: next byte in the same frame loads pair register
// - Unipolar bits map pairs, MSB first
// - Bipolar bits map pairs, MSB first
// - Bits 7:5 = 001 selects averaging
// - Averaging off one, else 4..32 conversions
// - Repeat count 4..16, repeat scan only
// - Serial-clocked mode disables averaging
// - Bits 7:4 = 0001 selects reset
// - Bit3 one clears FIFO, zero resets all
// - Power-up zeros, setup clock mode 10
// - Blocks start shut down until request
// - Temperature is high minus low minus offset
// - Temperature code step is one eighth degree
// - Result frame: four zeros, ten bits, two
// - Temperature frame: four zeros, twelve bits
// - Sample input rising, change output falling
// - Modes 0x start by pin, 1x by byte
// - Unipolar binary, bipolar two's complement output
// - Bit7 set means conversion byte, top priority unless a pair byte is owed
// - Unipolar wins when pair set in both
`timescale 1ns/100ps

module acd_command_decoder #(
	parameter logic [11:0] TEMP_OFFSET = 12'h0000 // Kelvin to Celsius shift, eighth-degree units
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic csN,
	input wire logic sdi,
	output logic sdo,
	input wire logic convertStartN,
	input wire logic scanDone,
	input acd_pkg::acd_result_s result,
	output acd_pkg::acd_cfg_s cfg,
	output logic convStart,
	output logic fifoClear
);

	// Link state on the serial clock and core state on the main clock
	acd_pkg::acd_link_s link;
	acd_pkg::acd_link_s next_link;
	acd_pkg::acd_core_s core;
	acd_pkg::acd_core_s next_core;
	// Bit position inside the byte being received
	logic [2:0] bitCount;
	// Bit position of the outgoing frame
	logic [3:0] outIndex;
	// Decoded byte event on the main clock
	logic newByte;
	logic [7:0] rxByte;
	logic csRise;
	logic pinRise;
	// Formatting helpers for the result word
	logic [11:0] tempCode;
	logic [9:0] signedCode;
	logic chanBipolar;
	logic [2:0] pairIndex;

	// Receive bit counter; select high parks it so each frame starts byte-aligned
	always_ff @(posedge sclk or posedge csN) begin
		if (csN) begin
			bitCount <= 3'h0;
		end else begin
			bitCount <= bitCount + 3'h1;
		end
	end

	// Shift register and byte hand-off toggle
	always_comb begin
		next_link = link;
		next_link.shift = {link.shift[5:0], sdi};
		if (bitCount == acd_pkg::LAST_BIT) begin
			// Eighth rising edge completes the byte
			next_link.byteHold = {link.shift, sdi};
			next_link.byteTog = ~link.byteTog;
		end
	end

	// Link registers; the serial clock stops between frames, so reset acts without it
	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			link <= '0;
		end else begin
			link <= next_link;
		end
	end

	// Output bit index advances on the falling edge so the host samples a stable bit
	always_ff @(negedge sclk or posedge csN) begin
		if (csN) begin
			outIndex <= 4'h0;
		end else begin
			outIndex <= outIndex + 4'h1;
		end
	end

	// Frame is sent most significant bit first; the word is not held still while select is low
	// The word crosses into the serial domain unsynchronised: a result captured in mid-frame
	// would tear the frame, so results must only be handed over while select is high
	assign sdo = core.outWord[4'hf - outIndex];

	// Byte events and pin edges seen once the second and third stages differ
	// The held byte is read across domains without its own synchroniser; it stays put for
	// eight serial clocks after each toggle, far longer than the three-stage toggle delay
	assign newByte = core.togSync[2] ^ core.togSync[1];
	assign rxByte = link.byteHold;
	assign csRise = core.csSync[1] & ~core.csSync[2];
	assign pinRise = core.pinSync[1] & ~core.pinSync[2];

	// Result formatting
	always_comb begin
		pairIndex = 3'h7 - result.channel[3:1];
		// Unipolar overrides bipolar for the same pair
		chanBipolar = core.bipolar[pairIndex] & ~core.unipolar[pairIndex];
		// Offset binary from the core becomes two's complement on bipolar pairs
		signedCode = {result.code[9] ^ chanBipolar, result.code[8:0]};
		// Difference of the two bias currents, then shifted to Celsius
		tempCode = result.tempHigh - result.tempLow - TEMP_OFFSET;
	end

	// Core next-state: synchronisers, byte decode, start logic
	always_comb begin
		next_core = core;
		next_core.togSync = {core.togSync[1:0], link.byteTog};
		next_core.csSync = {core.csSync[1:0], csN};
		next_core.pinSync = {core.pinSync[1:0], convertStartN};
		next_core.convStart = 1'b0;
		next_core.fifoClear = 1'b0;
		// A frame that ends drops any pair write still owed
		if (csRise) begin
			next_core.pending = acd_pkg::PAIR_NONE;
		end
		if (newByte) begin
			case (core.pending)
				// Byte after a setup byte goes straight to the pair register
				acd_pkg::PAIR_UNI: begin
					next_core.unipolar = rxByte;
					next_core.pending = acd_pkg::PAIR_NONE;
				end
				acd_pkg::PAIR_BI: begin
					next_core.bipolar = rxByte;
					next_core.pending = acd_pkg::PAIR_NONE;
				end
				default: begin
					if (rxByte[acd_pkg::SEL_CONV_BIT]) begin
						// Conversion byte beats every other selector
						next_core.conversion = rxByte;
						if (core.setup[acd_pkg::CLK_MODE_HI]) begin
							next_core.convStart = 1'b1;
						end
					end else if (rxByte[acd_pkg::SEL_SETUP_BIT]) begin
						next_core.setup = rxByte;
						if (rxByte[acd_pkg::PAIR_SEL_HI]) begin
							next_core.pending = rxByte[acd_pkg::PAIR_SEL_LO] ?
								acd_pkg::PAIR_BI : acd_pkg::PAIR_UNI;
						end else begin
							next_core.pending = acd_pkg::PAIR_NONE;
						end
					end else if (rxByte[acd_pkg::SEL_AVG_BIT]) begin
						next_core.averaging = rxByte;
					end else if (rxByte[acd_pkg::SEL_RESET_BIT]) begin
						// Low three bits are don't-care
						if (rxByte[acd_pkg::FIFO_ONLY_BIT]) begin
							next_core.fifoClear = 1'b1;
						end else begin
							// Full return to power-up values, blocks shut down
							next_core.setup = acd_pkg::SETUP_RESET;
							next_core.unipolar = acd_pkg::REG_RESET;
							next_core.bipolar = acd_pkg::REG_RESET;
							next_core.averaging = acd_pkg::REG_RESET;
							next_core.conversion = acd_pkg::REG_RESET;
							next_core.awake = 1'b0;
							next_core.fifoClear = 1'b1;
						end
					end
					// All-zero bytes fall through as fillers
				end
			endcase
		end
		// Pin-started conversions in the two pin modes, on release of the low pulse
		if (!core.setup[acd_pkg::CLK_MODE_HI] && pinRise) begin
			next_core.convStart = 1'b1;
		end
		// Blocks wake on a request and sleep after the scan
		if (next_core.convStart) begin
			next_core.awake = 1'b1;
		end else if (scanDone) begin
			next_core.awake = 1'b0;
		end
		// Capture a finished result as the next outgoing frame
		if (result.valid) begin
			if (result.isTemp) begin
				next_core.outWord = {acd_pkg::LEAD_ZEROS, tempCode};
			end else begin
				next_core.outWord = {acd_pkg::LEAD_ZEROS, signedCode, result.subBits};
			end
		end
	end

	// Core registers with synchronous reset to power-up values
	always_ff @(posedge mclk) begin
		if (reset) begin
			core <= '0;
			core.setup <= acd_pkg::SETUP_RESET;
			core.csSync <= 3'h7;
			core.pinSync <= 3'h7;
			core.awake <= 1'b0;
		end else begin
			core <= next_core;
		end
	end

	// Configuration presented to the converter core
	always_comb begin
		cfg.clockMode = core.setup[acd_pkg::CLK_MODE_HI:acd_pkg::CLK_MODE_LO];
		// Start pin doubles as analog input in the two byte-started modes
		cfg.pinIsAnalog = core.setup[acd_pkg::CLK_MODE_HI];
		cfg.refMode = core.setup[acd_pkg::REF_SEL_HI:acd_pkg::REF_SEL_LO];
		cfg.refInternal = ~core.setup[acd_pkg::REF_SEL_LO];
		cfg.refAlwaysOn = (cfg.refMode == acd_pkg::REF_INT_ON);
		cfg.refWakeNeeded = (cfg.refMode == acd_pkg::REF_INT_AUTO);
		cfg.refNegIsInput = (cfg.refMode != acd_pkg::REF_EXT_DIFF);
		cfg.unipolarPairs = core.unipolar;
		cfg.bipolarPairs = core.bipolar & ~core.unipolar;
		// Serial-clocked mode converts once per result
		if (!core.averaging[acd_pkg::AVG_ENABLE_BIT] || cfg.clockMode == acd_pkg::CLK_SERIAL) begin
			cfg.avgConversions = 6'h01;
		end else begin
			case (core.averaging[acd_pkg::AVG_COUNT_HI:acd_pkg::AVG_COUNT_LO])
				2'h0: cfg.avgConversions = 6'h04;
				2'h1: cfg.avgConversions = 6'h08;
				2'h2: cfg.avgConversions = 6'h10;
				default: cfg.avgConversions = 6'h20;
			endcase
		end
		cfg.scanMode = core.conversion[acd_pkg::SCAN_HI:acd_pkg::SCAN_LO];
		// Repeat count only matters in the repeated single-channel scan
		if (cfg.scanMode != acd_pkg::SCAN_REPEAT) begin
			cfg.repeatResults = 5'h01;
		end else begin
			case (core.averaging[acd_pkg::REPEAT_HI:acd_pkg::REPEAT_LO])
				2'h0: cfg.repeatResults = 5'h04;
				2'h1: cfg.repeatResults = 5'h08;
				2'h2: cfg.repeatResults = 5'h0c;
				default: cfg.repeatResults = 5'h10;
			endcase
		end
		cfg.channel = core.conversion[acd_pkg::CHAN_HI:acd_pkg::CHAN_LO];
		cfg.tempRequest = core.conversion[acd_pkg::TEMP_BIT];
		cfg.blocksAwake = core.awake;
	end

	assign convStart = core.convStart;
	assign fifoClear = core.fifoClear;

	// Checks on the main clock
	// Byte decode checks use the held byte, which is stable for many main clocks around newByte
	// Serial-domain counters are left to the bench, which sees every bit on the link
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	// Setup byte lands whole in the setup register
	property p_setupWrite;
		newByte && core.pending == acd_pkg::PAIR_NONE && rxByte[7:6] == 2'b01 |=> core.setup == $past(rxByte);
	endproperty
	a_setupWrite: assert property (p_setupWrite) else $error("setup byte not stored");

	// Pair select 0x leaves both pair registers alone
	property p_noPairAfter;
		newByte && core.pending == acd_pkg::PAIR_NONE && rxByte[7:6] == 2'b01 && !rxByte[1]
			|=> core.pending == acd_pkg::PAIR_NONE && $stable(core.unipolar) && $stable(core.bipolar);
	endproperty
	a_noPairAfter: assert property (p_noPairAfter) else $error("pair write armed wrongly");

	// Unipolar pair byte lands unless the frame is cut first
	property p_pairWrite;
		newByte && core.pending == acd_pkg::PAIR_UNI |=> core.unipolar == $past(rxByte) ##1 core.pending == acd_pkg::PAIR_NONE
			or csRise;
	endproperty
	a_pairWrite: assert property (p_pairWrite) else $error("unipolar pair byte lost");

	// Averaging byte lands and leaves the setup untouched
	property p_avgWrite;
		newByte && core.pending == acd_pkg::PAIR_NONE && rxByte[7:5] == 3'b001 |=> core.averaging == $past(rxByte)
			&& $stable(core.setup);
	endproperty
	a_avgWrite: assert property (p_avgWrite) else $error("averaging byte misrouted");

	// FIFO-only reset pulses the clear for one cycle and keeps the setup
	property p_fifoOnly;
		newByte && core.pending == acd_pkg::PAIR_NONE && rxByte[7:3] == 5'b00011 |=> fifoClear && $stable(core.setup)
			##1 !fifoClear;
	endproperty
	a_fifoOnly: assert property (p_fifoOnly) else $error("FIFO clear wrong");

	// Full reset restores power-up values and shuts the blocks down
	property p_fullReset;
		newByte && core.pending == acd_pkg::PAIR_NONE && rxByte[7:3] == 5'b00010
			|=> core.setup == acd_pkg::SETUP_RESET && core.unipolar == 8'h00 && !cfg.blocksAwake;
	endproperty
	a_fullReset: assert property (p_fullReset) else $error("full reset incomplete");

	property p_serialNoAvg;
		cfg.clockMode == acd_pkg::CLK_SERIAL |-> cfg.avgConversions == 6'h01;
	endproperty
	a_serialNoAvg: assert property (p_serialNoAvg) else $error("averaging in serial clock mode");

	// Bit 7 set means a conversion byte when no pair write is owed
	property p_convPriority;
		newByte && core.pending == acd_pkg::PAIR_NONE && rxByte[7] |=> core.conversion == $past(rxByte)
			&& $stable(core.setup) && $stable(core.averaging);
	endproperty
	a_convPriority: assert property (p_convPriority) else $error("conversion byte misrouted");

	property p_unipolarWins;
		(cfg.bipolarPairs & cfg.unipolarPairs) == 8'h00;
	endproperty
	a_unipolarWins: assert property (p_unipolarWins) else $error("pair both unipolar and bipolar");

	// Start pulse comes from the pin or the byte, never the wrong one
	property p_startSource;
		convStart |-> $past(core.setup[acd_pkg::CLK_MODE_HI]) ? $past(newByte) : $past(pinRise);
	endproperty
	a_startSource: assert property (p_startSource) else $error("start from wrong source");

	property p_wake;
		convStart |-> cfg.blocksAwake;
	endproperty
	a_wake: assert property (p_wake) else $error("blocks asleep after request");

	property p_frame;
		result.valid && !result.isTemp |=> core.outWord[15:12] == 4'h0 && core.outWord[1:0] == $past(result.subBits);
	endproperty
	a_frame: assert property (p_frame) else $error("result frame malformed");

	// Repeat count is forced to one outside the repeated single-channel scan
	property p_repeatOnly;
		cfg.scanMode != acd_pkg::SCAN_REPEAT |-> cfg.repeatResults == 5'h01;
	endproperty
	a_repeatOnly: assert property (p_repeatOnly) else $error("repeat count outside repeat scan");

	// Bipolar pair byte lands whatever its top bits hold
	property p_biPairWrite;
		newByte && core.pending == acd_pkg::PAIR_BI
			|=> core.bipolar == $past(rxByte) && core.pending == acd_pkg::PAIR_NONE;
	endproperty
	a_biPairWrite: assert property (p_biPairWrite) else $error("bipolar pair byte lost");

	// FIFO clear comes only from a reset-register byte
	property p_fifoSource;
		fifoClear |-> $past(newByte) && $past(core.pending) == acd_pkg::PAIR_NONE && $past(rxByte[7:4]) == 4'h1;
	endproperty
	a_fifoSource: assert property (p_fifoSource) else $error("FIFO clear from a non-reset byte");

	// Averaging count follows the two count bits when enabled outside serial mode
	property p_avgCount;
		core.averaging[acd_pkg::AVG_ENABLE_BIT] && cfg.clockMode != acd_pkg::CLK_SERIAL
			|-> cfg.avgConversions == (6'h04 << core.averaging[acd_pkg::AVG_COUNT_HI:acd_pkg::AVG_COUNT_LO]);
	endproperty
	a_avgCount: assert property (p_avgCount) else $error("averaging count wrong");

	c_setupThenPair: cover property (newByte && core.pending == acd_pkg::PAIR_BI);
	c_byteStart: cover property (convStart && core.setup[acd_pkg::CLK_MODE_HI]);
	c_pinStart: cover property (convStart && !core.setup[acd_pkg::CLK_MODE_HI]);
	c_fifoClear: cover property (fifoClear);
	c_fullReset: cover property (fifoClear && core.setup == acd_pkg::SETUP_RESET);

endmodule : acd_command_decoder

// ===== acd_host_model.sv
// Behavioural serial host that drives the command link and reads result frames
`timescale 1ns/100ps

module acd_host_model (
	output logic sclk,
	output logic csN,
	output logic sdi,
	input wire logic sdo
);
	// Half of the 48 ns link period
	localparam time HALF = 24;

	// Link parked: clock still, select high, data line held high
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		sdi = 1'b1;
	end

	// One bit: data set while the clock is low, output read at the rising edge
	task automatic bitCycle(input logic din, output logic dout);
		sdi = din;
		#HALF;
		sclk = 1'b1;
		dout = sdo;
		#HALF;
		sclk = 1'b0;
	endtask : bitCycle

	// Select drops a whole period ahead of the first rising edge
	task automatic openFrame;
		csN = 1'b0;
		#HALF;
	endtask : openFrame

	// Released data line shows the inverse so a stale value is never trusted
	task automatic closeFrame;
		#HALF;
		csN = 1'b1;
		sdi = ~sdi;
		#HALF;
	endtask : closeFrame

	// One command byte in a frame of its own
	task automatic sendByte(input logic [7:0] b);
		logic d;
		openFrame();
		for (int i = 7; i >= 0; i--) begin
			bitCycle(b[i], d);
		end
		closeFrame();
	endtask : sendByte

	// Two bytes under one select, 16 clocks; also returns the frame shifted out
	task automatic sendWord(input logic [15:0] w, output logic [15:0] rx);
		logic d;
		openFrame();
		for (int i = 15; i >= 0; i--) begin
			bitCycle(w[i], d);
			rx[i] = d;
		end
		closeFrame();
	endtask : sendWord
endmodule : acd_host_model

// ===== acd_pkg.sv
// Shared constants and types for the converter command decoder
package acd_pkg;

	// Input byte selector bits, tested in priority order
	localparam int SEL_CONV_BIT = 7;
	localparam int SEL_SETUP_BIT = 6;
	localparam int SEL_AVG_BIT = 5;
	localparam int SEL_RESET_BIT = 4;
	// Setup byte fields
	localparam int CLK_MODE_HI = 5;
	localparam int CLK_MODE_LO = 4;
	localparam int REF_SEL_HI = 3;
	localparam int REF_SEL_LO = 2;
	localparam int PAIR_SEL_HI = 1;
	localparam int PAIR_SEL_LO = 0;
	// Averaging byte fields
	localparam int AVG_ENABLE_BIT = 4;
	localparam int AVG_COUNT_HI = 3;
	localparam int AVG_COUNT_LO = 2;
	localparam int REPEAT_HI = 1;
	localparam int REPEAT_LO = 0;
	// Reset byte field: one clears the result FIFO only
	localparam int FIFO_ONLY_BIT = 3;
	// Conversion byte fields
	localparam int CHAN_HI = 6;
	localparam int CHAN_LO = 3;
	localparam int SCAN_HI = 2;
	localparam int SCAN_LO = 1;
	localparam int TEMP_BIT = 0;
	// Power-up values
	localparam logic [7:0] SETUP_RESET = 8'h20;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Mode codes
	localparam logic [1:0] CLK_SERIAL = 2'h3;
	localparam logic [1:0] SCAN_REPEAT = 2'h2;
	localparam logic [1:0] REF_INT_AUTO = 2'h0;
	localparam logic [1:0] REF_INT_ON = 2'h2;
	localparam logic [1:0] REF_EXT_DIFF = 2'h3;
	// Serial clock ceiling in serial-clocked conversion mode
	localparam int SERIAL_CLK_MAX_KHZ = 4800;
	// Frame layout: leading zeros ahead of the value
	localparam logic [3:0] LEAD_ZEROS = 4'h0;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// Pending pair-register write after a setup byte
	typedef enum logic [1:0] {
		PAIR_NONE = 2'b00,
		PAIR_UNI = 2'b10,
		PAIR_BI = 2'b11
	} acd_pair_e;

	// Configuration seen by the converter core
	typedef struct packed {
		logic [1:0] clockMode;
		logic pinIsAnalog;
		logic [1:0] refMode;
		logic refInternal;
		logic refAlwaysOn;
		logic refWakeNeeded;
		logic refNegIsInput;
		logic [7:0] unipolarPairs;
		logic [7:0] bipolarPairs;
		logic [5:0] avgConversions;
		logic [4:0] repeatResults;
		logic [1:0] scanMode;
		logic [3:0] channel;
		logic tempRequest;
		logic blocksAwake;
	} acd_cfg_s;

	// One result from the analog core
	typedef struct packed {
		logic valid;
		logic isTemp;
		logic [3:0] channel;
		logic [9:0] code;
		logic [1:0] subBits;
		logic [11:0] tempHigh;
		logic [11:0] tempLow;
	} acd_result_s;

	// Link-side state on the serial clock
	typedef struct packed {
		logic [6:0] shift;
		logic [7:0] byteHold;
		logic byteTog;
	} acd_link_s;

	// Core-side state on the main clock
	typedef struct packed {
		logic [7:0] setup;
		logic [7:0] unipolar;
		logic [7:0] bipolar;
		logic [7:0] averaging;
		logic [7:0] conversion;
		acd_pair_e pending;
		logic awake;
		logic [2:0] togSync;
		logic [2:0] csSync;
		logic [2:0] pinSync;
		logic convStart;
		logic fifoClear;
		logic [15:0] outWord;
	} acd_core_s;

endpackage : acd_pkg

// ===== tb_adc_config_command_decoder.sv
// Self-checking bench for the converter command decoder
`timescale 1ns/100ps

module tb_adc_config_command_decoder;
	localparam logic [11:0] T_OFS = 12'h0111; // Small offset so the subtraction shows
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic sclk, csN, sdi, sdo;
	logic convertStartN = 1'b1;
	logic scanDone = 1'b0;
	acd_pkg::acd_result_s result = '0;
	acd_pkg::acd_cfg_s cfg;
	logic convStart, fifoClear;
	int badCount = 0;
	int numChecks = 0;
	int startCount = 0; // Start pulses seen
	int clearCount = 0; // FIFO clear pulses seen
	int s0;
	logic [15:0] rx;

	always #5 mclk = ~mclk;

	acd_command_decoder #(.TEMP_OFFSET(T_OFS)) i_dut (.mclk(mclk), .reset(reset), .sclk(sclk), .csN(csN),
		.sdi(sdi), .sdo(sdo), .convertStartN(convertStartN), .scanDone(scanDone), .result(result),
		.cfg(cfg), .convStart(convStart), .fifoClear(fifoClear));

	acd_host_model i_host (.sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo));

	// Pulse counters; read at the falling edge, half a cycle after each pulse launches
	always @(negedge mclk) begin
		if (convStart === 1'b1) startCount++;
		if (fifoClear === 1'b1) clearCount++;
	end

	// Verdict and end of run
	task automatic completeRun;
		$display("checks %0d mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : completeRun

	// Compare a value of any width up to 16 bits
	task automatic checkVal(input string n, input logic [15:0] e, input logic [15:0] g);
		numChecks++;
		if (g !== e) begin
			badCount++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : checkVal

	task automatic endTest(input string n);
		$display("test %s done, mismatches so far %0d", n, badCount);
	endtask : endTest

	// Decode takes a few core cycles after the frame; 8 covers it with room
	task automatic settle;
		repeat (8) @(negedge mclk);
	endtask : settle

	task automatic wrByte(input logic [7:0] b);
		i_host.sendByte(b);
		settle();
	endtask : wrByte

	task automatic wrWord(input logic [15:0] w);
		i_host.sendWord(w, rx);
		settle();
	endtask : wrWord

	// Start pin low pulse, then compare the start pulse count
	task automatic pinPulse(input int expAdd);
		s0 = startCount;
		@(negedge mclk) convertStartN = 1'b0;
		repeat (3) @(negedge mclk);
		convertStartN = 1'b1;
		settle();
		checkVal("pinStart", 16'(s0 + expAdd), 16'(startCount));
	endtask : pinPulse

	// One result handed over while idle, then read back as a 16-clock frame
	task automatic readResult(input logic t, input logic [3:0] ch, input logic [9:0] cd, input logic [15:0] e);
		@(negedge mclk);
		result.valid = 1'b1;
		result.isTemp = t;
		result.channel = ch;
		result.code = cd;
		result.subBits = 2'b10;
		result.tempHigh = 12'h0900;
		result.tempLow = 12'h0100;
		@(negedge mclk) result.valid = 1'b0;
		settle();
		i_host.sendWord(16'h0000, rx);
		checkVal("frame", e, rx);
	endtask : readResult

	initial begin
		#600000;
		$display("mismatch watchdog expected end seen hang");
		badCount++;
		completeRun();
	end

	initial begin
		#3;
		repeat (6) @(posedge mclk);
		@(negedge mclk) reset = 1'b0;
		repeat (4) @(negedge mclk);
		checkVal("clockMode", 16'h0002, cfg.clockMode);
		checkVal("uni", 16'h0000, cfg.unipolarPairs);
		checkVal("avg", 16'h0001, cfg.avgConversions);
		checkVal("awake", 16'h0000, cfg.blocksAwake);
		endTest("defaults");
		// Every clock and reference code in one sweep
		for (int m = 0; m < 16; m++) begin
			wrByte({2'b01, 4'(m), 2'b00});
			checkVal("clockMode", 16'(m[3:2]), cfg.clockMode);
			checkVal("pinAnalog", 16'(m[3]), cfg.pinIsAnalog);
			checkVal("refMode", 16'(m[1:0]), cfg.refMode);
			checkVal("refWake", 16'(m[1:0] == 2'b00), cfg.refWakeNeeded);
			checkVal("refOn", 16'(m[1:0] == 2'b10), cfg.refAlwaysOn);
			checkVal("refInt", 16'(!m[0]), cfg.refInternal);
			checkVal("refNeg", 16'(m[1:0] != 2'b11), cfg.refNegIsInput);
		end
		endTest("setup");
		// Data bytes with bit 7 set still land in the pair registers
		wrWord(16'h62A5);
		checkVal("uni", 16'h00A5, cfg.unipolarPairs);
		wrWord(16'h635A);
		checkVal("bi", 16'h005A, cfg.bipolarPairs);
		wrWord(16'h6100);
		checkVal("uniKeep", 16'h00A5, cfg.unipolarPairs);
		checkVal("biKeep", 16'h005A, cfg.bipolarPairs);
		wrWord(16'h63FF);
		checkVal("biMasked", 16'h005A, cfg.bipolarPairs);
		endTest("pairs");
		// Conversion byte: channel 3, repeat scan, temperature
		s0 = startCount;
		wrByte(8'h9D);
		checkVal("byteStart", 16'(s0 + 1), 16'(startCount));
		checkVal("chan", 16'h0003, cfg.channel);
		checkVal("scan", 16'h0002, cfg.scanMode);
		checkVal("temp", 16'h0001, cfg.tempRequest);
		checkVal("awake", 16'h0001, cfg.blocksAwake);
		@(negedge mclk) scanDone = 1'b1;
		@(negedge mclk) scanDone = 1'b0;
		settle();
		checkVal("asleep", 16'h0000, cfg.blocksAwake);
		for (int k = 0; k < 32; k++) begin
			wrByte({3'b001, 5'(k)});
			checkVal("avg", k[4] ? 16'(6'd4 << k[3:2]) : 16'h0001, cfg.avgConversions);
			checkVal("repeat", 16'(4 * (k[1:0] + 1)), cfg.repeatResults);
		end
		wrByte(8'h70);
		checkVal("avgSerial", 16'h0001, cfg.avgConversions);
		endTest("averaging");
		// Start source follows the clock mode
		wrByte(8'h40);
		pinPulse(1);
		s0 = startCount;
		wrByte(8'h9D);
		checkVal("noByteStart", 16'(s0), 16'(startCount));
		wrByte(8'h60);
		pinPulse(0);
		// Single conversion of channel 0: repeat count no longer applies
		s0 = startCount;
		wrByte(8'h87);
		checkVal("byteStart2", 16'(s0 + 1), 16'(startCount));
		checkVal("repeatOff", 16'h0001, cfg.repeatResults);
		endTest("start");
		readResult(1'b0, 4'h0, 10'h2B3, {4'h0, 10'h2B3, 2'b10});
		readResult(1'b0, 4'h2, 10'h2B3, {4'h0, 10'h0B3, 2'b10});
		readResult(1'b1, 4'h0, 10'h000, {4'h0, 12'h0900 - 12'h0100 - T_OFS});
		endTest("frames");
		// FIFO-only clear leaves the registers, full reset restores defaults
		wrByte(8'h5C);
		s0 = clearCount;
		wrByte(8'h18);
		checkVal("fifoClr", 16'(s0 + 1), 16'(clearCount));
		checkVal("keepClk", 16'h0001, cfg.clockMode);
		checkVal("keepUni", 16'h00A5, cfg.unipolarPairs);
		s0 = clearCount;
		wrByte(8'h17);
		checkVal("fullClr", 16'(s0 + 1), 16'(clearCount));
		checkVal("fullAwake", 16'h0000, cfg.blocksAwake);
		checkVal("fullClk", 16'h0002, cfg.clockMode);
		checkVal("fullRef", 16'h0000, cfg.refMode);
		checkVal("fullUni", 16'h0000, cfg.unipolarPairs);
		checkVal("fullBi", 16'h0000, cfg.bipolarPairs);
		checkVal("fullAvg", 16'h0001, cfg.avgConversions);
		endTest("reset");
		completeRun();
	end
endmodule : tb_adc_config_command_decoder
